// File: verilog/rsi_map.svh
/*
  register indices, reset values and timing counts of the reset state initializer.
  assumes byte registers on an 8-bit plain register port, index equals address.
*/
`ifndef RSI_MAP_SVH
`define RSI_MAP_SVH

// ==========================================================
// register indices
`define RSI_LATCH_BASE 6'h00
`define RSI_LATCH_COUNT 9
`define RSI_PORT_TWO 6'h02
`define RSI_IND_PORT 6'h07
`define RSI_IND_BIT 0
`define RSI_DIR_BASE 6'h09
`define RSI_DIR_COUNT 7
`define RSI_PULL_BASE 6'h10
`define RSI_PULL_COUNT 6
`define RSI_INPUT_SWITCH 6'h16
`define RSI_MEM_SIZE 6'h17
`define RSI_CPU_CLK 6'h18
`define RSI_INT_OSC 6'h19
`define RSI_MAIN_CLK 6'h1A
`define RSI_MAIN_OSC 6'h1B
`define RSI_SETTLE_SEL 6'h1C
`define RSI_SETTLE_STAT 6'h1D
`define RSI_WIDE_BASE 6'h1E
`define RSI_WIDE_COUNT 10
`define RSI_BYTE_BASE 6'h28
`define RSI_BYTE_COUNT 8
`define RSI_INTV_BASE 6'h30
`define RSI_INTV_COUNT 7
`define RSI_WATCH 6'h37
`define RSI_STATUS 6'h38
`define RSI_REG_COUNT 57

// ==========================================================
// reset values and timing
`define RSI_RV_ZERO 8'h00
`define RSI_RV_DIR 8'hFF
`define RSI_RV_MEM_SIZE 8'hCF
`define RSI_RV_SETTLE_SEL 8'h05
`define RSI_VECTOR_LO 16'h0000
`define RSI_VECTOR_HI 16'h0001
`define RSI_SETTLE_BASE 16
`define RSI_STAT_SETTLE 0
`define RSI_STAT_RUN 1

`endif

// File: verilog/rsi_pkg.sv
/*
  types shared by the reset state initializer modules.
  assumes rsi_map.svh supplies every number.
*/
package rsi_pkg;

  // ==========================================================
  // types
  typedef enum logic [1:0] {ST_RESET, ST_SETTLE, ST_RUN} rsi_state_e_t;

  typedef struct packed {
    logic ext_reset_n;   // external pin, low requests reset
    logic wdt_overflow;  // watchdog overflow
    logic clkmon_stop;   // clock monitor saw oscillator stop
    logic poc_detect;    // power-on-clear detection
    logic lvi_detect;    // low-voltage detection
  } rsi_src_t;

  typedef struct packed {
    logic req;
    logic wdt;
  } rsi_comb_t;

  typedef struct packed {
    rsi_state_e_t st;
    logic [15:0] cnt;
    logic start;
    logic rd_hw;
    logic [7:0] hw_data;
  } rsi_core_t;

endpackage

// File: verilog/rsi_reset_combiner.sv
/*
  merges every reset source into one registered request.
  assumes all sources synchronous to clk and active while reset is wanted.
*/
`timescale 1ns/1ps

module rsi_reset_combiner
(
  input wire logic clk,                // core clock
  input wire logic reset,              // synchronous system reset
  input wire rsi_pkg::rsi_src_t src,   // reset sources
  output logic reset_req,              // combined request, registered
  output logic wdt_clear               // watchdog logic reset, registered
);
  import rsi_pkg::*;

  rsi_comb_t r_r;
  rsi_comb_t r_nxt;

  // ==========================================================
  // request merge
  // a watchdog-caused reset must also clear the watchdog itself
  always_comb
  begin
    r_nxt.req = reset | ~src.ext_reset_n | src.wdt_overflow | src.clkmon_stop
                | src.poc_detect | src.lvi_detect;
    r_nxt.wdt = reset | r_nxt.req;
  end

  // registered so the request is glitch free
  always_ff @(posedge clk)
  begin
    if (reset)
      r_r <= '{req: 1'b1, wdt: 1'b1};
    else
      r_r <= r_nxt;
  end

  assign reset_req = r_r.req;
  assign wdt_clear = r_r.wdt;

  a_wdt_self_clear: assert property (@(posedge clk) disable iff (reset)
    src.wdt_overflow |=> wdt_clear)
    else $error("watchdog not cleared by its own overflow");

endmodule // rsi_reset_combiner

// File: verilog/rsi_reg_bank.sv
/*
  byte register bank holding the power-up state, with registered read data.
  assumes clear is held for at least one clock and writes arrive only while running.
*/
`timescale 1ns/1ps
`include "rsi_map.svh"

module rsi_reg_bank #(
  parameter int DEPTH = `RSI_REG_COUNT,
  parameter int AW = 6
)
(
  input wire logic clk,                 // core clock
  input wire logic clear,               // load reset values
  input wire logic wr,                  // write strobe
  input wire logic rd,                  // read strobe
  input wire logic [AW-1:0] addr,       // register index
  input wire logic [7:0] wdata,         // write data
  output logic [7:0] rdata,             // read data, one cycle later
  output logic [DEPTH*8-1:0] q_all      // every byte, flat
);
  import rsi_pkg::*;

  logic [7:0] mem_r [DEPTH];
  logic [7:0] rdata_r;

  // reset value of each index
  function automatic logic [7:0] rv(input int i);
    if (i >= `RSI_DIR_BASE && i < `RSI_DIR_BASE + `RSI_DIR_COUNT)
      return `RSI_RV_DIR;
    if (i == `RSI_MEM_SIZE)
      return `RSI_RV_MEM_SIZE;
    if (i == `RSI_SETTLE_SEL)
      return `RSI_RV_SETTLE_SEL;
    return `RSI_RV_ZERO;
  endfunction

  // ==========================================================
  // storage; port two keeps whatever it held, its reset value is undefined
  for (genvar g = 0; g < DEPTH; g++)
  begin : g_byte
    always_ff @(posedge clk)
    begin
      if (clear && g != `RSI_PORT_TWO)
        mem_r[g] <= rv(g);
      else if (wr && !clear && addr == AW'(g))
        mem_r[g] <= wdata;
    end
    assign q_all[g*8 +: 8] = mem_r[g];
  end

  // ==========================================================
  // read port; unmapped indices read zero
  always_ff @(posedge clk)
  begin
    if (rd)
      rdata_r <= (int'(addr) < DEPTH) ? mem_r[addr] : `RSI_RV_ZERO;
  end

  assign rdata = rdata_r;

endmodule // rsi_reg_bank

// File: verilog/reset_state_initializer.sv
/*
  reset state initializer: merges reset sources, loads the power-up state of the
  port, clock and timer registers, holds pins idle through the settle wait and
  starts the core at the reset vector.
  assumes all inputs synchronous to clk; register port strobes one cycle long.
*/
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "rsi_map.svh"

module reset_state_initializer #(
  parameter int AW = 6,
  parameter int SETTLE_BASE = `RSI_SETTLE_BASE
)
(
  input wire logic clk,                     // core clock, 100 MHz
  input wire logic reset,                   // synchronous reset, high
  input wire rsi_pkg::rsi_src_t src,        // reset sources
  input wire logic [AW-1:0] addr,           // register index
  input wire logic [7:0] wdata,             // write data
  input wire logic wr,                      // write strobe
  input wire logic rd,                      // read strobe
  output logic [7:0] rdata,                 // read data, cycle after rd
  output logic reset_indicator_port_bit,    // indicator pin level
  output logic reset_indicator_oe,          // indicator pin drive enable
  output logic pins_idle,                   // other pins high impedance
  output logic cpu_hold,                    // core held stopped
  output logic cpu_start,                   // one-cycle start pulse
  output logic [15:0] vector_lo_addr,       // low byte of reset vector
  output logic [15:0] vector_hi_addr,       // high byte of reset vector
  output logic wdt_clear,                   // watchdog reset
  output logic [`RSI_REG_COUNT*8-1:0] state_q // loaded register state
);
  import rsi_pkg::*;

  rsi_core_t r_r;
  rsi_core_t r_nxt;
  logic reset_req;
  logic [7:0] bank_rdata;
  logic [15:0] wait_cycles;
  logic [7:0] settle_stat;
  logic ind_latch;
  logic bank_wr;
  logic bank_rd;
  logic hw_sel;

  // byte of the flat state at a register index
  function automatic logic [7:0] byte_at(input logic [`RSI_REG_COUNT*8-1:0] q, input int idx);
    return q[idx*8 +: 8];
  endfunction

  // true where the index is one of the bytes that the hardware answers itself
  function automatic logic is_hw(input logic [AW-1:0] a);
    return a == `RSI_SETTLE_STAT || a == `RSI_STATUS;
  endfunction

  // ==========================================================
  // reset request merge
  rsi_reset_combiner rsi_reset_combiner_inst (
    .clk(clk),
    .reset(reset),
    .src(src),
    .reset_req(reset_req),
    .wdt_clear(wdt_clear)
  );

  // ==========================================================
  // register state; software writes it only while the core runs, reads it in any state
  assign bank_wr = wr && r_r.st == ST_RUN;
  assign bank_rd = rd && !is_hw(addr);
  assign hw_sel = rd && is_hw(addr);

  rsi_reg_bank #(
    .DEPTH(`RSI_REG_COUNT),
    .AW(AW)
  ) rsi_reg_bank_inst (
    .clk(clk),
    .clear(reset_req),
    .wr(bank_wr),
    .rd(bank_rd),
    .addr(addr),
    .wdata(wdata),
    .rdata(bank_rdata),
    .q_all(state_q)
  );

  // ==========================================================
  // settle wait length follows the settle select field
  // only three low bits used so the count stays inside 16 bits
  assign wait_cycles = 16'(SETTLE_BASE << byte_at(state_q, `RSI_SETTLE_SEL) % 8);

  // settle status: one bit per elapsed stage, zero through reset
  always_comb
  begin
    settle_stat = `RSI_RV_ZERO;
    for (int i = 0; i < 8; i++)
    begin
      if (r_r.st == ST_RUN)
        settle_stat[i] = (i <= int'(byte_at(state_q, `RSI_SETTLE_SEL) % 8));
      else if (r_r.st == ST_SETTLE)
        settle_stat[i] = (int'(r_r.cnt) >= (SETTLE_BASE << i));
    end
  end

  // ==========================================================
  // sequencer: reset, settle wait, run
  always_comb
  begin
    r_nxt = r_r;
    r_nxt.start = 1'b0;
    r_nxt.rd_hw = hw_sel;
    if (hw_sel)
      r_nxt.hw_data = (addr == `RSI_SETTLE_STAT) ? settle_stat
                      : 8'({r_r.st == ST_RUN, r_r.st == ST_SETTLE});
    unique case (r_r.st)
      ST_RESET:
      begin
        r_nxt.cnt = 16'h0000;
        if (!reset_req)
          r_nxt.st = ST_SETTLE;
      end
      ST_SETTLE:
      begin
        if (reset_req)
          r_nxt.st = ST_RESET;
        else if (r_r.cnt == wait_cycles - 16'h0001)
        begin
          r_nxt.st = ST_RUN;
          r_nxt.start = 1'b1;
        end
        else
          r_nxt.cnt = r_r.cnt + 16'h0001;
      end
      ST_RUN:
      begin
        if (reset_req)
          r_nxt.st = ST_RESET;
      end
    endcase
  end

  // one register for all sequencer state
  always_ff @(posedge clk)
  begin
    if (reset)
      r_r <= '{st: ST_RESET, cnt: 16'h0000, start: 1'b0, rd_hw: 1'b0, hw_data: 8'h00};
    else
      r_r <= r_nxt;
  end

  // ==========================================================
  // outputs
  // indicator drops the moment a reset is seen, before the latch is reloaded
  assign ind_latch = state_q[`RSI_IND_PORT*8 + `RSI_IND_BIT];
  assign reset_indicator_port_bit = !reset_req && r_r.st != ST_RESET && ind_latch;
  assign reset_indicator_oe = 1'b1;
  assign pins_idle = r_r.st != ST_RUN;
  assign cpu_hold = r_r.st != ST_RUN;
  assign cpu_start = r_r.start;
  assign vector_lo_addr = `RSI_VECTOR_LO;
  assign vector_hi_addr = `RSI_VECTOR_HI;
  assign rdata = r_r.rd_hw ? r_r.hw_data : bank_rdata;

  // ==========================================================
  // checks
  a_ind_low_reset: assert property (@(posedge clk) disable iff (reset)
    reset_req |-> !reset_indicator_port_bit)
    else $error("indicator not low during reset");

  a_ind_held_high: assert property (@(posedge clk) disable iff (reset)
    (reset_indicator_port_bit && !reset_req) ##1 !reset_req |-> reset_indicator_port_bit
      || !ind_latch)
    else $error("indicator fell without reset or write");

  a_latch_clear: assert property (@(posedge clk) disable iff (reset)
    reset_req |=> byte_at(state_q, `RSI_LATCH_BASE) == `RSI_RV_ZERO
      && byte_at(state_q, `RSI_IND_PORT) == `RSI_RV_ZERO
      && byte_at(state_q, `RSI_LATCH_BASE + 8) == `RSI_RV_ZERO)
    else $error("port latch not cleared");

  a_port_two_kept: assert property (@(posedge clk) disable iff (reset)
    reset_req && !bank_wr |=> byte_at(state_q, `RSI_PORT_TWO) === $past(byte_at(state_q, `RSI_PORT_TWO)))
    else $error("port two latch changed by reset");

  a_dir_ones: assert property (@(posedge clk) disable iff (reset)
    reset_req |=> byte_at(state_q, `RSI_DIR_BASE) == `RSI_RV_DIR
      && byte_at(state_q, `RSI_DIR_BASE + 6) == `RSI_RV_DIR)
    else $error("direction register not all ones");

  a_pull_clear: assert property (@(posedge clk) disable iff (reset)
    reset_req |=> byte_at(state_q, `RSI_PULL_BASE) == `RSI_RV_ZERO
      && byte_at(state_q, `RSI_PULL_BASE + 5) == `RSI_RV_ZERO)
    else $error("pull-up select not cleared");

  a_switch_clear: assert property (@(posedge clk) disable iff (reset)
    reset_req |=> byte_at(state_q, `RSI_INPUT_SWITCH) == `RSI_RV_ZERO)
    else $error("input switch control not cleared");

  a_mem_size_value: assert property (@(posedge clk) disable iff (reset)
    reset_req |=> byte_at(state_q, `RSI_MEM_SIZE) == `RSI_RV_MEM_SIZE)
    else $error("memory size select not CF");

  a_clock_regs: assert property (@(posedge clk) disable iff (reset)
    reset_req |=> byte_at(state_q, `RSI_CPU_CLK) == `RSI_RV_ZERO && byte_at(state_q, `RSI_INT_OSC) == `RSI_RV_ZERO
      && byte_at(state_q, `RSI_MAIN_CLK) == `RSI_RV_ZERO && byte_at(state_q, `RSI_MAIN_OSC) == `RSI_RV_ZERO)
    else $error("clock register not cleared");

  a_settle_regs: assert property (@(posedge clk) disable iff (reset)
    reset_req |=> byte_at(state_q, `RSI_SETTLE_SEL) == `RSI_RV_SETTLE_SEL && settle_stat == `RSI_RV_ZERO)
    else $error("settle select or status wrong after reset");

  a_wide_count: assert property (@(posedge clk) disable iff (reset)
    reset_req |=> {byte_at(state_q, `RSI_WIDE_BASE + 1), byte_at(state_q, `RSI_WIDE_BASE)} == 16'h0000)
    else $error("wide timer count not cleared");

  a_wide_capcomp: assert property (@(posedge clk) disable iff (reset)
    reset_req |=> state_q[(`RSI_WIDE_BASE + 2)*8 +: 32] == 32'h0000_0000)
    else $error("capture/compare not cleared");

  a_wide_ctrl: assert property (@(posedge clk) disable iff (reset)
    reset_req |=> state_q[(`RSI_WIDE_BASE + 6)*8 +: 32] == 32'h0000_0000)
    else $error("wide timer control not cleared");

  a_byte_timers: assert property (@(posedge clk) disable iff (reset)
    reset_req |=> state_q[`RSI_BYTE_BASE*8 +: 64] == 64'h0)
    else $error("byte timer not cleared");

  a_intv_timers: assert property (@(posedge clk) disable iff (reset)
    reset_req |=> state_q[`RSI_INTV_BASE*8 +: 56] == 56'h0)
    else $error("interval timer not cleared");

  a_watch_mode: assert property (@(posedge clk) disable iff (reset)
    reset_req |=> byte_at(state_q, `RSI_WATCH) == `RSI_RV_ZERO)
    else $error("watch timer mode not cleared");

  a_start_vector: assert property (@(posedge clk) disable iff (reset)
    cpu_start |-> $past(r_r.st) == ST_SETTLE && !cpu_hold && vector_lo_addr == 16'h0000
      && vector_hi_addr == 16'h0001)
    else $error("start not from settle or wrong vector");

  a_idle_pins: assert property (@(posedge clk) disable iff (reset)
    $fell(reset_req) |-> pins_idle [*2] ##1 (pins_idle || cpu_start))
    else $error("pins released before settle wait");

endmodule // reset_state_initializer

// File: testbench/reset_state_initializer_test.sv
/*
  self-checking bench for the reset state initializer: dirties every register but status,
  fires each reset source in turn and checks pins, start pulse and power-up state.
  assumes rsi_map.svh and rsi_pkg are compiled first; settle base shortened to 1.
*/
`timescale 1ns/1ps
`include "rsi_map.svh"

module reset_state_initializer_test;
  import rsi_pkg::*;

  // ==========================================================
  // signals and design instance
  localparam logic [4:0] SRC_IDLE = 5'h10; // pin high, internal sources quiet
  logic clk;
  logic reset;
  rsi_src_t src;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic reset_indicator_port_bit;
  logic reset_indicator_oe;
  logic pins_idle;
  logic cpu_hold;
  logic cpu_start;
  logic [15:0] vector_lo_addr;
  logic [15:0] vector_hi_addr;
  logic wdt_clear;
  logic [`RSI_REG_COUNT*8-1:0] state_q;
  int err_total;
  int checks_done;
  int n;
  int starts;

  // short settle base keeps each release at 32 cycles instead of 512
  reset_state_initializer #(.SETTLE_BASE(1)) reset_state_initializer_inst (
    .clk(clk),
    .reset(reset),
    .src(src),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .reset_indicator_port_bit(reset_indicator_port_bit),
    .reset_indicator_oe(reset_indicator_oe),
    .pins_idle(pins_idle),
    .cpu_hold(cpu_hold),
    .cpu_start(cpu_start),
    .vector_lo_addr(vector_lo_addr),
    .vector_hi_addr(vector_hi_addr),
    .wdt_clear(wdt_clear),
    .state_q(state_q)
  );

  // ==========================================================
  // clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // the whole run needs about 1000 cycles, so 20000 means a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end

  // ==========================================================
  // helpers
  task automatic report_and_stop();
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // case inequality so an unknown never counts as a match
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // hardware-answered read data stand only in the cycle after the strobe, so sample there
  task automatic reg_read(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check("read data", 16'(rdata), 16'(exp));
  endtask

  // bounded wait for the core to start, counting start pulses on the way
  task automatic wait_run(output int cyc, output int pulses);
    cyc = 0;
    pulses = 0;
    while (cpu_hold !== 1'b0 && cyc < 200)
    begin
      @(posedge clk);
      #1;
      cyc++;
      if (cpu_start === 1'b1)
        pulses++;
    end
    repeat (3)
    begin
      @(posedge clk);
      #1;
      if (cpu_start === 1'b1)
        pulses++;
    end
  endtask

  // expected power-up value of a register index
  function automatic logic [7:0] rv(input int i);
    if (i >= `RSI_DIR_BASE && i < `RSI_DIR_BASE + `RSI_DIR_COUNT)
      return 8'hFF;
    if (i == `RSI_MEM_SIZE)
      return 8'hCF;
    if (i == `RSI_SETTLE_SEL)
      return 8'h05;
    return 8'h00;
  endfunction

  // ==========================================================
  // main sequence
  initial
  begin
    err_total = 0;
    checks_done = 0;
    reset = 1'b1;
    src = SRC_IDLE;
    addr = 6'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check("indicator in reset", 16'(reset_indicator_port_bit), 16'h0000);
    check("indicator drive", 16'(reset_indicator_oe), 16'h0001);
    check("pins idle in reset", 16'(pins_idle), 16'h0001);
    check("watchdog clear", 16'(wdt_clear), 16'h0001);
    check("vector low", vector_lo_addr, 16'h0000);
    check("vector high", vector_hi_addr, 16'h0001);
    @(posedge clk);
    reset <= 1'b0;
    wait_run(n, starts);
    check("start pulses", 16'(starts), 16'h0001);
    reg_read(`RSI_MEM_SIZE, 8'hCF);
    reg_read(`RSI_DIR_BASE, 8'hFF);
    reg_read(`RSI_STATUS, 8'h02);
    reg_read(`RSI_SETTLE_STAT, 8'h3F);
    reg_read(6'h3F, 8'h00);
    // sources 0..4 in struct order, 5 is the reset input itself
    for (int k = 0; k < 6; k++)
    begin
      for (int i = 0; i <= `RSI_WATCH; i++)
        reg_write(6'(i), (i == `RSI_IND_PORT) ? 8'h01 : 8'hA5);
      reg_read(`RSI_CPU_CLK, 8'hA5);
      check("indicator raised", 16'(reset_indicator_port_bit), 16'h0001);
      @(posedge clk);
      if (k == 5)
        reset <= 1'b1;
      else
        src <= SRC_IDLE ^ (5'h10 >> k);
      repeat (4) @(posedge clk);
      #1;
      check("indicator in reset", 16'(reset_indicator_port_bit), 16'h0000);
      check("watchdog clear", 16'(wdt_clear), 16'h0001);
      check("pins idle in reset", 16'(pins_idle), 16'h0001);
      check("core held", 16'(cpu_hold), 16'h0001);
      for (int i = 0; i <= `RSI_WATCH; i++)
        if (i != `RSI_PORT_TWO)
          check("reset value", 16'(state_q[i*8+:8]), 16'(rv(i)));
      @(posedge clk);
      reset <= 1'b0;
      src <= SRC_IDLE;
      #1;
      wait_run(n, starts);
      // pins must stay idle through the whole settle wait of 32 cycles
      check("settle length", 16'(n >= 32 && n <= 36), 16'h0001);
      check("start pulses", 16'(starts), 16'h0001);
      check("pins released", 16'(pins_idle), 16'h0000);
      check("indicator stays low", 16'(reset_indicator_port_bit), 16'h0000);
    end
    report_and_stop();
  end
endmodule // reset_state_initializer_test
